// >>> hdl/acoc_top.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// acoc_fifo : sample buffer
// ------------------------------------------------------------------
module acoc_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("fifo depth must be a power of two, at least 2");
    end
  end

  assign in_ready  = (cnt_ff != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_ff[rd_ff];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule // acoc_fifo

module acoc_top #(
  parameter int unsigned DATA_W     = acoc_pkg::DATA_W,
  parameter int unsigned FIFO_DEPTH = acoc_pkg::FIFO_DEPTH,
  parameter int unsigned LATENCY    = acoc_pkg::LATENCY
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [DATA_W-1:0] core_code,
  input  wire logic              core_over_hi,
  input  wire logic              core_over_lo,
  input  wire logic              core_valid,
  input  wire logic [3:0]        div_ratio,
  input  wire logic              rate_change,
  input  wire logic              rate_below_min,
  input  wire logic              sync_pin,
  input  wire logic              chip_select_low,
  input  wire logic              serial_data_stabilizer_pin,
  input  wire logic              serial_clock_format_pin,
  input  wire logic              power_down_pin,
  input  wire logic              output_enable_low_pin,
  input  wire logic              lvds_select_pin,
  input  wire logic              reduced_swing_select_pin,
  input  wire logic [7:0]        cfg_stab_value,
  input  wire logic [2:0]        cfg_sync_ctrl,
  input  wire logic              cfg_sync_write,
  input  wire logic              cfg_power_down,
  input  wire logic              cfg_standby,
  input  wire logic              cfg_pin_is_standby,
  input  wire logic              cfg_lvds,
  input  wire logic              cfg_reduced_swing,
  input  wire logic [1:0]        cfg_format,
  input  wire logic              cfg_output_disable,
  input  wire logic              cfg_dco_invert,
  input  wire logic              capture_ready,
  output logic                   core_ready,
  output logic                   serial_mode,
  output logic                   stab_active,
  output logic                   stab_locked,
  output logic                   int_clk,
  output logic                   sample_tick,
  output logic                   powered_down,
  output logic                   standby,
  output logic                   lvds_mode,
  output logic                   reduced_swing,
  output logic [DATA_W-1:0]      data_out,
  output logic                   over_out,
  output logic                   data_oe_n,
  output logic                   data_clock_output,
  output logic                   dco_oe_n
);
  localparam int unsigned WORD_W = DATA_W + 1;
  localparam int unsigned HALF_W = DATA_W / 2;

  initial begin
    if (LATENCY < 3 || DATA_W < 2 || (DATA_W % 2) != 0) begin
      $error("latency below 3 or odd data width is not supported");
    end
  end

  // ------------------------------------------------------------------
  // configuration mode and selections
  // ------------------------------------------------------------------
  logic        serial_ff;
  logic        stab_en;
  logic        lvds;
  logic [1:0]  fmt;
  logic        pd_req;
  logic        sb_req;
  logic        halt;
  logic        out_off;
  logic [3:0]  ratio;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_ff <= 1'b0;
    end else if (!chip_select_low) begin
      serial_ff <= 1'b1;
    end
  end

  always_comb begin
    stab_en = serial_ff ? (cfg_stab_value != acoc_pkg::STAB_OFF_VALUE)
                        : serial_data_stabilizer_pin;
    fmt = serial_ff ? cfg_format
                    : (serial_clock_format_pin ? 2'(acoc_pkg::ACOC_FMT_TWOS)
                                               : 2'(acoc_pkg::ACOC_FMT_OFFSET));
    lvds          = lvds_select_pin | (serial_ff & cfg_lvds);
    reduced_swing = lvds & (reduced_swing_select_pin | (serial_ff & cfg_reduced_swing));
    // pin acts as power-down or standby
    pd_req = (power_down_pin & ~(serial_ff & cfg_pin_is_standby))
           | (serial_ff & cfg_power_down);
    sb_req = ~pd_req & serial_ff
           & (cfg_standby | (power_down_pin & cfg_pin_is_standby));
    halt = pd_req | sb_req;
    out_off = pd_req | output_enable_low_pin | (serial_ff & cfg_output_disable);
    // out-of-range ratios fall back to two
    ratio = (div_ratio < acoc_pkg::DIV_MIN || div_ratio > acoc_pkg::DIV_MAX)
          ? acoc_pkg::DIV_MIN : div_ratio;
  end

  assign serial_mode  = serial_ff;
  assign powered_down = pd_req;
  assign standby      = sb_req;
  assign lvds_mode    = lvds;

  // ------------------------------------------------------------------
  // sync pulse handling
  // ------------------------------------------------------------------
  logic sync_d_ff;
  logic armed_ff;
  logic sync_rise;
  logic resync;

  assign sync_rise = sync_pin & ~sync_d_ff;
  // every pulse, or first after write
  assign resync = sync_rise & cfg_sync_ctrl[acoc_pkg::SYNC_EN_BIT]
                & (~cfg_sync_ctrl[acoc_pkg::SYNC_ONCE_BIT] | armed_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_d_ff <= 1'b0;
      armed_ff  <= 1'b0;
    end else begin
      sync_d_ff <= sync_pin;
      // a write in the pulse cycle re-arms, so it wins
      if (cfg_sync_write) begin
        armed_ff <= 1'b1;
      end else if (resync) begin
        armed_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // stabilizer lock
  // ------------------------------------------------------------------
  logic [3:0] ratio_d_ff;
  logic       stab_d_ff;
  logic [7:0] lock_ff;
  logic       relock;

  assign relock      = rate_change | (ratio != ratio_d_ff) | (stab_en & ~stab_d_ff);
  assign stab_locked = (lock_ff == '0);
  // bypass until locked or when slow
  assign stab_active = stab_en & stab_locked & ~rate_below_min;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ratio_d_ff <= acoc_pkg::DIV_MIN;
      stab_d_ff  <= 1'b0;
      lock_ff    <= 8'(acoc_pkg::RELOCK_CYC);
    end else begin
      ratio_d_ff <= ratio;
      stab_d_ff  <= stab_en;
      if (relock) begin
        lock_ff <= 8'(acoc_pkg::RELOCK_CYC);
      end else if (lock_ff != '0) begin
        lock_ff <= lock_ff - 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // clock divider
  // ------------------------------------------------------------------
  logic [3:0] div_ff;
  logic [3:0] fall_pt;
  logic       rise_tick;
  logic       fall_tick;
  logic       int_clk_ff;

  // odd ratio without stabilizer keeps input skew
  assign fall_pt   = (stab_active || !ratio[0]) ? (ratio >> 1) : ((ratio + 4'h1) >> 1);
  assign rise_tick = ~halt & (div_ff == '0);
  assign fall_tick = ~halt & (div_ff == fall_pt);
  assign sample_tick = rise_tick;
  assign int_clk     = int_clk_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff     <= '0;
      int_clk_ff <= 1'b0;
    end else if (resync) begin
      div_ff     <= '0;
      int_clk_ff <= 1'b0;
    end else if (!halt) begin
      div_ff <= (div_ff >= ratio - 4'h1) ? 4'h0 : div_ff + 4'h1;
      if (rise_tick) begin
        int_clk_ff <= 1'b1;
      end else if (fall_tick) begin
        int_clk_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // code mapping and pipeline
  // ------------------------------------------------------------------
  function automatic logic [DATA_W-1:0] fmt_code(input logic [DATA_W-1:0] ob,
                                                 input logic [1:0] f);
    logic [DATA_W-1:0] r;
    r = ob;
    case (f)
      2'(acoc_pkg::ACOC_FMT_TWOS): r = ob ^ acoc_pkg::MSB_MASK;
      2'(acoc_pkg::ACOC_FMT_GRAY): r = ob ^ (ob >> 1);
      default:                     r = ob;
    endcase
    return r;
  endfunction

  logic [DATA_W-1:0] clamp;
  logic [WORD_W-1:0] pipe_ff [LATENCY-1];
  logic [LATENCY-2:0] pv_ff;
  logic               fifo_out_valid;
  logic [WORD_W-1:0]  fifo_out_data;
  logic               fifo_pop;

  always_comb begin
    if (core_over_hi) begin
      clamp = acoc_pkg::CODE_MAX;
    end else if (core_over_lo) begin
      clamp = acoc_pkg::CODE_MIN;
    end else begin
      clamp = core_code;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pv_ff <= '0;
    end else if (rise_tick) begin
      pv_ff <= {pv_ff[LATENCY-3:0], core_valid};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < LATENCY - 1; gi++) begin : g_pipe
      always_ff @(posedge clk) begin
        if (rise_tick) begin
          if (gi == 0) begin
            pipe_ff[gi] <= {core_over_hi | core_over_lo, fmt_code(clamp, fmt)};
          end else begin
            pipe_ff[gi] <= pipe_ff[gi-1];
          end
        end
      end
    end
  endgenerate

  acoc_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (rise_tick & pv_ff[LATENCY-2]),
    .in_ready  (core_ready),
    .in_data   (pipe_ff[LATENCY-2]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // ------------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------------
  logic [WORD_W-1:0] word_ff;
  logic [DATA_W-1:0] dout_ff;
  logic              load_tick;

  // lvds loads half a cycle later
  assign load_tick = lvds ? fall_tick : rise_tick;
  assign fifo_pop  = load_tick & capture_ready & fifo_out_valid;

  function automatic logic [HALF_W-1:0] lane_pick(input logic [DATA_W-1:0] w,
                                                  input logic odd);
    logic [HALF_W-1:0] r;
    r = '0;
    for (int i = 0; i < HALF_W; i++) begin
      r[i] = w[2 * i + (odd ? 1 : 0)];
    end
    return r;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_ff <= {1'b0, acoc_pkg::CODE_ZERO};
      dout_ff <= '0;
    end else if (fifo_pop) begin
      word_ff <= fifo_out_data;
      // even bits change at falling edge
      dout_ff <= lvds ? DATA_W'(lane_pick(fifo_out_data[DATA_W-1:0], 1'b0))
                      : fifo_out_data[DATA_W-1:0];
    end else if (lvds && rise_tick) begin
      // odd bits change at rising edge
      dout_ff <= DATA_W'(lane_pick(word_ff[DATA_W-1:0], 1'b1));
    end
  end

  assign data_out  = dout_ff;
  assign over_out  = word_ff[DATA_W];
  assign data_oe_n = out_off;
  assign dco_oe_n  = out_off;
  assign data_clock_output = int_clk_ff ^ (serial_ff & cfg_dco_invert & ~lvds);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pd_floats: assert property (pd_req |-> data_oe_n && dco_oe_n)
    else $error("outputs driven in power-down");
  a_oe_pin: assert property (output_enable_low_pin |-> data_oe_n)
    else $error("output enable pin high but data driven");
  a_oe_serial: assert property (serial_ff && cfg_output_disable |-> dco_oe_n)
    else $error("serial disable ignored");
  a_mode_sticks: assert property ($rose(serial_ff) |=> serial_ff [*8])
    else $error("serial mode left");
  a_relock_wait: assert property ($rose(relock) |=> !stab_locked [*8])
    else $error("locked too early after change");
  a_lock_bypass: assert property (!stab_locked |-> !stab_active)
    else $error("stabilizer used while unlocked");
  a_slow_bypass: assert property (rate_below_min |-> !stab_active)
    else $error("stabilizer used below min rate");
  a_sync_restart: assert property (resync |=> div_ff == '0 && !int_clk_ff)
    else $error("divider not restarted by sync");
  a_sync_once: assert property (resync && cfg_sync_ctrl[2] && !cfg_sync_write
                                |=> !armed_ff)
    else $error("one-shot sync still armed");
  a_even_duty: assert property ($rose(int_clk_ff) && ratio == 4'h4 && !halt && !resync
                                ##1 ratio == 4'h4 && !halt && !resync
                                |-> int_clk_ff ##1 !int_clk_ff)
    else $error("even ratio not half duty");
  a_div_period: assert property (rise_tick && ratio == 4'h3 && !resync
                                 ##1 (ratio == 4'h3 && !halt && !resync) [*2]
                                 |=> rise_tick || halt)
    else $error("divide by three period wrong");
  a_clamp_hi: assert property (core_over_hi |-> clamp == acoc_pkg::CODE_MAX)
    else $error("overrange not clamped");
  a_cmos_load: assert property (fifo_pop |-> (lvds ? fall_tick : rise_tick))
    else $error("output loaded on wrong edge");

  c_lvds_load: cover property (fifo_pop && lvds);
  c_resync:    cover property (resync);
  c_relocked:  cover property ($rose(stab_locked));
  c_fifo_full: cover property (!core_ready);
endmodule // acoc_top

// >>> common/acoc_pkg.sv
package acoc_pkg;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned RELOCK_MAX_NS = 5000;
  // longest relock wait, whole cycles rounded down
  localparam int unsigned RELOCK_CYC    = RELOCK_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned LATENCY       = 12;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam int unsigned DATA_W        = 16;
  // ------------------------------------------------------------------
  // divider
  // ------------------------------------------------------------------
  localparam logic [3:0] DIV_MIN        = 4'h2;
  localparam logic [3:0] DIV_MAX        = 4'h8;
  // ------------------------------------------------------------------
  // configuration values
  // ------------------------------------------------------------------
  localparam logic [7:0] STAB_OFF_VALUE = 8'h00;
  localparam int unsigned SYNC_EN_BIT   = 1;
  localparam int unsigned SYNC_ONCE_BIT = 2;
  localparam logic [15:0] CODE_ZERO     = 16'h8000;
  localparam logic [15:0] CODE_MAX      = 16'hFFFF;
  localparam logic [15:0] CODE_MIN      = 16'h0000;
  localparam logic [15:0] MSB_MASK      = 16'h8000;

  typedef enum logic [1:0] {
    ACOC_FMT_OFFSET,
    ACOC_FMT_TWOS,
    ACOC_FMT_GRAY,
    ACOC_FMT_RSVD
  } acoc_fmt_t;
endpackage

// >>> test/acoc_capture_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// acoc_capture_model : receiver register at the far side
// ------------------------------------------------------------------
module acoc_capture_model (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        stall,
  input  wire logic [acoc_pkg::DATA_W-1:0] data_out,
  input  wire logic                        data_clock_output,
  input  wire logic                        data_oe_n,
  output logic                             capture_ready,
  output logic      [acoc_pkg::DATA_W-1:0] cap_word,
  output logic      [15:0]                 cap_count
);
  // slow receiver: the stall request lands one cycle late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_ready <= 1'b0;
    end else begin
      capture_ready <= !stall;
    end
  end

  // once per data clock
  // mid-period capture, data changes near the rising data clock edge
  always_ff @(negedge data_clock_output or negedge rst_n) begin
    if (!rst_n) begin
      cap_word  <= '0;
      cap_count <= 16'h0000;
    end else if (!data_oe_n && capture_ready) begin
      cap_word  <= data_out;
      cap_count <= cap_count + 16'h0001;
    end
  end
endmodule // acoc_capture_model

// >>> test/acoc_top_tb.sv
`timescale 1ns/1ps

module acoc_top_tb;
  localparam logic [15:0] CORNER [4] = '{16'h0000, 16'h8000, 16'hffff, 16'h7fff};
  logic [15:0] core_code, cap_word, cap_count, data_out, d, c0;
  logic [7:0]  cfg_stab_value;
  logic [3:0]  div_ratio;
  logic [2:0]  cfg_sync_ctrl;
  logic [1:0]  cfg_format;
  logic        clk, rst_n, core_over_hi, core_over_lo, core_valid, rate_change, rate_below_min;
  logic        sync_pin, chip_select_low, serial_data_stabilizer_pin, serial_clock_format_pin;
  logic        power_down_pin, output_enable_low_pin, lvds_select_pin, reduced_swing_select_pin;
  logic        cfg_sync_write, cfg_power_down, cfg_standby, cfg_pin_is_standby, cfg_lvds;
  logic        cfg_reduced_swing, cfg_output_disable, cfg_dco_invert, capture_ready, stall;
  logic        core_ready, serial_mode, stab_active, stab_locked, int_clk, sample_tick;
  logic        powered_down, standby, lvds_mode, reduced_swing, over_out, data_oe_n;
  logic        data_clock_output, dco_oe_n;
  int          err_count, checks, hi, per, n, r, s;

  acoc_top i_dut (
    .clk, .rst_n, .core_code, .core_over_hi, .core_over_lo, .core_valid, .div_ratio,
    .rate_change, .rate_below_min, .sync_pin, .chip_select_low, .serial_data_stabilizer_pin,
    .serial_clock_format_pin, .power_down_pin, .output_enable_low_pin, .lvds_select_pin,
    .reduced_swing_select_pin, .cfg_stab_value, .cfg_sync_ctrl, .cfg_sync_write,
    .cfg_power_down, .cfg_standby, .cfg_pin_is_standby, .cfg_lvds, .cfg_reduced_swing,
    .cfg_format, .cfg_output_disable, .cfg_dco_invert, .capture_ready, .core_ready,
    .serial_mode, .stab_active, .stab_locked, .int_clk, .sample_tick, .powered_down,
    .standby, .lvds_mode, .reduced_swing, .data_out, .over_out, .data_oe_n,
    .data_clock_output, .dco_oe_n
  );

  acoc_capture_model i_cap (
    .clk, .rst_n, .stall, .data_out, .data_clock_output, .data_oe_n, .capture_ready,
    .cap_word, .cap_count
  );

  always #20 clk = ~clk;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // stops where the coming edge samples the input word
  task automatic next_tick;
    int i;
    step(1);
    for (i = 0; i < 20 && sample_tick !== 1'b1; i++) step(1);
  endtask

  task automatic measure;
    int i;
    hi = 0;
    for (i = 0; i < 40 && int_clk !== 1'b0; i++) step(1);
    for (i = 0; i < 40 && int_clk !== 1'b1; i++) step(1);
    for (i = 0; i < 40 && int_clk === 1'b1; i++) begin
      step(1);
      hi++;
    end
    per = hi;
    for (i = 0; i < 40 && int_clk !== 1'b1; i++) begin
      step(1);
      per++;
    end
  endtask

  function automatic logic [16:0] expect_word(logic [15:0] c, logic h, logic l, logic [1:0] f);
    logic [15:0] v;
    v = h ? acoc_pkg::CODE_MAX : (l ? acoc_pkg::CODE_MIN : c);
    if (f == 2'h1) v = v ^ acoc_pkg::MSB_MASK;
    else if (f == 2'h2) v = v ^ (v >> 1);
    return {h | l, v};
  endfunction

  task automatic stream(input logic [1:0] f, input int cnt);
    logic [16:0] q[$];
    int          j, k;
    for (j = 0; j < cnt; j++) begin
      next_tick;
      if (j >= 13) check({over_out, data_out}, q[j-13]);
      k = (j < 2) ? j : int'($urandom % 8);
      core_code = (j < 4) ? CORNER[j] : 16'($urandom);
      core_over_hi = (k == 0);
      core_over_lo = (k == 1);
      q.push_back(expect_word(core_code, core_over_hi, core_over_lo, f));
    end
  endtask

  task automatic lvds_check;
    logic [7:0] ev, od;
    logic       se, so;
    int         i;
    core_code = 16'ha5c3;
    core_over_hi = 1'b0;
    core_over_lo = 1'b0;
    se = 1'b0;
    so = 1'b0;
    for (i = 0; i < 8; i++) begin
      ev[i] = core_code[2*i];
      od[i] = core_code[2*i+1];
    end
    repeat (20) next_tick;
    for (i = 0; i < 8; i++) begin
      step(1);
      check(data_out[15:8], 8'h00);
      se |= (data_out[7:0] === ev);
      so |= (data_out[7:0] === od);
    end
    check({se, so}, 2'b11);
  endtask

  // sync raised two cycles after a tick, natural tick six cycles away
  task automatic sync_try(input logic hit);
    int i;
    next_tick;
    step(2);
    sync_pin = 1'b1;
    for (i = 1; i < 12; i++) begin
      step(1);
      if (sample_tick === 1'b1) break;
    end
    sync_pin = 1'b0;
    check(i <= 2, hit);
  endtask

  initial begin
    #(40 * 40000);
    err_count++;
    conclude;
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {clk, rst_n, core_code, core_over_hi, core_over_lo, core_valid, div_ratio, rate_change,
     rate_below_min, sync_pin, chip_select_low, serial_data_stabilizer_pin,
     serial_clock_format_pin, power_down_pin, output_enable_low_pin, lvds_select_pin,
     reduced_swing_select_pin, cfg_stab_value, cfg_sync_ctrl, cfg_sync_write, cfg_power_down,
     cfg_standby, cfg_pin_is_standby, cfg_lvds, cfg_reduced_swing, cfg_format,
     cfg_output_disable, cfg_dco_invert, stall} = '0;
    chip_select_low = 1'b1;
    serial_data_stabilizer_pin = 1'b1;
    core_valid = 1'b1;
    div_ratio = 4'h2;
    cfg_stab_value = 8'h01;
    void'($urandom(32'h297c));
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    step(3);
    check(serial_mode, 1'b0);
    check(lvds_mode, 1'b0);
    lvds_select_pin = 1'b1;
    reduced_swing_select_pin = 1'b1;
    step(1);
    check({lvds_mode, reduced_swing}, 2'b11);
    lvds_select_pin = 1'b0;
    reduced_swing_select_pin = 1'b0;
    cfg_output_disable = 1'b1;
    cfg_lvds = 1'b1;
    step(1);
    check({lvds_mode, data_oe_n}, 2'b00);
    cfg_output_disable = 1'b0;
    cfg_lvds = 1'b0;
    output_enable_low_pin = 1'b1;
    step(1);
    check({data_oe_n, dco_oe_n}, 2'b11);
    output_enable_low_pin = 1'b0;
    step(1);
    check({data_oe_n, dco_oe_n}, 2'b00);
    power_down_pin = 1'b1;
    step(1);
    check({powered_down, data_oe_n, dco_oe_n}, 3'b111);
    n = 0;
    repeat (20) begin
      step(1);
      if (sample_tick !== 1'b0) n++;
    end
    check(n, 0);
    power_down_pin = 1'b0;
    step(1);
    check({powered_down, data_oe_n}, 2'b00);
    for (s = 1; s >= 0; s--) begin
      serial_data_stabilizer_pin = s[0];
      for (r = 2; r <= 8; r++) begin
        div_ratio = r[3:0];
        step(130);
        check(stab_active, s[0]);
        measure;
        check(per, r);
        check(hi, (s == 0 && r % 2 == 1) ? (r + 1) / 2 : r / 2);
      end
    end
    serial_data_stabilizer_pin = 1'b1;
    div_ratio = 4'h2;
    step(130);
    rate_change = 1'b1;
    step(1);
    rate_change = 1'b0;
    check(stab_active, 1'b0);
    for (n = 0; n < 200 && stab_locked !== 1'b1; n++) step(1);
    check(n >= 124 && n <= 126, 1'b1);
    rate_below_min = 1'b1;
    step(1);
    check(stab_active, 1'b0);
    rate_below_min = 1'b0;
    for (s = 0; s < 2; s++) begin
      serial_clock_format_pin = s[0];
      stream(s[1:0], 30);
    end
    serial_clock_format_pin = 1'b0;
    lvds_select_pin = 1'b1;
    lvds_check;
    lvds_select_pin = 1'b0;
    stall = 1'b1;
    repeat (25) next_tick;
    check(core_ready, 1'b0);
    d = data_out;
    repeat (4) next_tick;
    check(data_out, d);
    stall = 1'b0;
    // hold off new words until the backlog drains, else latency stays long
    core_valid = 1'b0;
    repeat (25) next_tick;
    check(core_ready, 1'b1);
    core_valid = 1'b1;
    stream(2'h0, 20);
    c0 = cap_count;
    repeat (16) next_tick;
    check(cap_word, data_out);
    check(cap_count - c0, 16'h0010);
    chip_select_low = 1'b0;
    step(2);
    chip_select_low = 1'b1;
    step(2);
    check(serial_mode, 1'b1);
    cfg_stab_value = acoc_pkg::STAB_OFF_VALUE;
    step(2);
    check(stab_active, 1'b0);
    cfg_stab_value = 8'h5a;
    step(130);
    check(stab_active, 1'b1);
    cfg_output_disable = 1'b1;
    step(1);
    check({data_oe_n, dco_oe_n}, 2'b11);
    cfg_output_disable = 1'b0;
    cfg_power_down = 1'b1;
    step(1);
    check({powered_down, data_oe_n}, 2'b11);
    cfg_power_down = 1'b0;
    cfg_standby = 1'b1;
    step(1);
    check({standby, powered_down, data_oe_n}, 3'b100);
    cfg_standby = 1'b0;
    cfg_pin_is_standby = 1'b1;
    power_down_pin = 1'b1;
    step(1);
    check({standby, powered_down}, 2'b10);
    power_down_pin = 1'b0;
    cfg_pin_is_standby = 1'b0;
    cfg_lvds = 1'b1;
    cfg_reduced_swing = 1'b1;
    step(1);
    check({lvds_mode, reduced_swing}, 2'b11);
    cfg_lvds = 1'b0;
    cfg_reduced_swing = 1'b0;
    cfg_dco_invert = 1'b1;
    repeat (4) begin
      step(1);
      check(data_clock_output, {~int_clk});
    end
    cfg_dco_invert = 1'b0;
    for (s = 0; s < 4; s++) begin
      cfg_format = s[1:0];
      stream((s == 3) ? 2'h0 : s[1:0], 30);
    end
    div_ratio = 4'h8;
    cfg_sync_ctrl = 3'b010;
    sync_try(1'b1);
    sync_try(1'b1);
    cfg_sync_ctrl = 3'b110;
    cfg_sync_write = 1'b1;
    step(1);
    cfg_sync_write = 1'b0;
    sync_try(1'b1);
    sync_try(1'b0);
    conclude;
  end
endmodule // acoc_top_tb
